// File: include/rbf_pkg.sv
// shared constants and carrier types for the return burst formatter
package rbf_pkg;
	localparam int CELL_BYTES     = 53;
	localparam int PACKET_BYTES   = 188;
	localparam int BYTE_W         = 8;
	localparam int FIFO_DEPTH     = 8;
	localparam int CNT_W          = 16;
	localparam int LOGON_BITS     = 112;
	localparam int PRE_MAX_BITS   = 256;
	localparam int PRE_LEN_W      = 9;
	// capability A and capability C field positions
	localparam int CAPA_SECURITY  = 23;
	localparam int CAPA_NETMGMT   = 22;
	localparam int CAPA_CELLCONN  = 21;
	localparam int CAPA_PACKET    = 20;
	localparam int CAPA_RX_HI     = 19;
	localparam int CAPA_RX_LO     = 18;
	localparam int CAPA_ACQ_REQ   = 17;
	localparam int CAPA_SHARED    = 16;
	localparam int CAPA_SW_HI     = 15;
	localparam int CAPA_SW_LO     = 8;
	localparam int CAPA_HOP_HI    = 7;
	localparam int CAPA_HOP_LO    = 6;
	localparam int CAPA_SLOTTING  = 5;
	localparam int CAPA_CLASS_HI  = 4;
	localparam int CAPA_CLASS_LO  = 3;
	localparam int CAPA_ROUTE_CAP = 2;
	localparam int CAPA_MODE_HI   = 1;
	localparam int CAPA_MODE_LO   = 0;
	localparam int CAPC_MOB_HI    = 6;
	localparam int CAPC_MOB_LO    = 4;
	localparam logic [1:0] RX_RESERVED    = 2'h3;
	localparam logic [1:0] MODE_RESERVED  = 2'h3;
	localparam logic [1:0] VERSION_OLD    = 2'h3;
	localparam logic [1:0] VERSION_NEW    = 2'h2;
	localparam logic [2:0] MOB_LOC_UPDATE = 3'h0;
	localparam logic [2:0] MOB_NONE       = 3'h7;
	localparam logic [7:0] RESERVED_FILL  = 8'h00;
	localparam logic       TYPE_LOGON     = 1'b1;

	typedef enum logic [1:0] {
		RBF_TRAFFIC,
		RBF_UPKEEP,
		RBF_ACQUISITION,
		RBF_LOGON
	} rbf_kind_type;

	typedef struct packed {
		logic       security;
		logic       network_mgmt;
		logic       cell_connect;
		logic       packet_traffic;
		logic [1:0] receivers;
		logic       acq_required;
		logic       shared_outdoor_unit_flag;
		logic [7:0] sw_version;
		logic [1:0] hop_range;
		logic       multi_carrier_slotting;
		logic [1:0] terminal_class;
		logic       route_capable;
		logic [1:0] terminal_mode;
	} rbf_capa_type;

	typedef struct packed {
		rbf_capa_type cap_a;
		logic [47:0]  mac_address;
		logic [15:0]  downlink_route_field;
		logic [4:0]   cap_b;
		logic [1:0]   version;
		logic [7:0]   cap_c;
	} rbf_logon_type;

	typedef struct packed {
		rbf_kind_type   kind;
		logic           packet_mode;
		logic [7:0]     prefix_bytes;
		logic [CNT_W-1:0] slot_bytes;
		logic [CNT_W-1:0] overhead_bytes;
		logic [7:0]     access_field_length;
		logic [PRE_LEN_W-1:0] preamble_bits;
		logic           contention;
		logic           logged_on;
		logic           hub_allows_update;
	} rbf_burst_type;
endpackage

// File: hw/rbf_fifo.sv
// parameterised valid/ready byte fifo for the payload path
`timescale 1ns/100ps
module rbf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// full/empty straight from the occupancy count
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	//////////////////////////////////////////////////////////////////////////
	// storage has no reset, it is only read behind a valid count
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers wrap at depth
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// File: hw/rbf_logon_word.sv
// packs the logon signalling burst word from capability inputs
`timescale 1ns/100ps
module rbf_logon_word (
	input  wire rbf_pkg::rbf_logon_type          fields,
	output logic [rbf_pkg::LOGON_BITS-1:0]       word,
	output logic                                 fields_ok
);
	// reserved codes in receivers, mode and version are refused
	wire rx_ok   = fields.cap_a.receivers != rbf_pkg::RX_RESERVED;
	wire mode_ok = fields.cap_a.terminal_mode != rbf_pkg::MODE_RESERVED;
	wire ver_ok  = (fields.version == rbf_pkg::VERSION_OLD) ||
		(fields.version == rbf_pkg::VERSION_NEW);

	assign fields_ok = rx_ok && mode_ok && ver_ok;

	// field order fixed; msb of the word goes out first
	// capability A bits pass straight through from the struct, b23 down to b0
	assign word = {fields.cap_a, fields.mac_address, fields.downlink_route_field,
		fields.cap_b, fields.version, fields.cap_c, rbf_pkg::RESERVED_FILL,
		rbf_pkg::TYPE_LOGON};
endmodule

// File: hw/rbf_formatter.sv
// return burst formatter: traffic, upkeep, acquisition and logon bursts to serial bits
`timescale 1ns/100ps
// Overview of operation
// - cell traffic is whole 53-byte cells after an optional byte prefix
// - packet traffic is whole 188-byte transport packets
// - packet traffic optional; advertised by capability A packet bit
// - packet count from slot bytes minus other field bytes
// - upkeep burst: preamble then optional access field bytes
// - upkeep bursts allowed in contention or assigned slots
// - acquisition preamble length and pattern come from slot table inputs
// - logon fields packed in fixed order after the preamble
// - logon type identifier bit always one
// - route field 16 bits, value passed through as given
// - capability A b23..b20 feature flags
// - b19-b18 receiver count, code 11 refused
// - b17 set when acquisition burst needed
// - b16 shared outdoor unit flag
// - b15-b8 system-dependent software version
// - b7-b6 hopping range code
// - b5 dynamic multi-carrier slotting
// - b4-b3 class, b2 route insert capability
// - b1-b0 terminal mode, code 11 refused
// - location update logon only when hub allows it
// - logon only when not logged on
// - guard interval flagged after each burst
// - fields in order, msb first, bytes msb first
// - version 11 or 10 only
// - capability C b6-b4 mobility field
module rbf_formatter (
	input  wire logic                          core_clk,
	input  wire logic                          nrst,
	input  wire logic                          start,
	input  wire rbf_pkg::rbf_burst_type        burst,
	input  wire rbf_pkg::rbf_logon_type        logon,
	input  wire logic [rbf_pkg::PRE_MAX_BITS-1:0] preamble_pattern,
	input  wire logic [7:0]                    in_byte,
	input  wire logic                          in_valid,
	output logic                               in_ready,
	input  wire logic                          bit_enable,
	output logic                               tx_bit,
	output logic                               tx_valid,
	output logic                               tx_first,
	output logic                               tx_guard,
	output logic                               busy,
	output logic                               refused,
	output logic [rbf_pkg::CNT_W-1:0]          unit_count
);
	typedef enum logic [2:0] {
		RBF_IDLE,
		RBF_PREAMBLE,
		RBF_LOGON_BITS,
		RBF_PAYLOAD,
		RBF_GUARD
	} rbf_state_type;

	rbf_state_type                state;
	rbf_pkg::rbf_burst_type       cfg;
	logic [rbf_pkg::LOGON_BITS-1:0] logon_shift;
	logic [rbf_pkg::PRE_MAX_BITS-1:0] pre_shift;
	logic [rbf_pkg::PRE_LEN_W-1:0] pre_left;
	logic [rbf_pkg::CNT_W-1:0]    bytes_left;
	logic [2:0]                   bit_idx;
	logic [7:0]                   cur_byte;
	logic                         byte_loaded;
	logic                         first_pending;
	logic [6:0]                   logon_left;

	// fifo drain side
	logic [7:0] f_data;
	logic       f_valid;
	logic       f_ready;

	// logon word
	logic [rbf_pkg::LOGON_BITS-1:0] logon_word;
	logic                           logon_ok;

	//////////////////////////////////////////////////////////////////////////
	// payload bytes buffered so the source sees back-pressure
	rbf_fifo #(
		.WIDTH (rbf_pkg::BYTE_W),
		.DEPTH (rbf_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.in_data   (in_byte),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);

	rbf_logon_word u_logon (
		.fields    (logon),
		.word      (logon_word),
		.fields_ok (logon_ok)
	);

	//////////////////////////////////////////////////////////////////////////
	// whole units per slot: division used twice, so kept as a function
	function automatic logic [rbf_pkg::CNT_W-1:0] units_in(
		input logic [rbf_pkg::CNT_W-1:0] avail,
		input logic [rbf_pkg::CNT_W-1:0] unit
	);
		units_in = avail / unit;
	endfunction

	localparam logic [rbf_pkg::CNT_W-1:0] CELL_W = rbf_pkg::CNT_W'(rbf_pkg::CELL_BYTES);
	localparam logic [rbf_pkg::CNT_W-1:0] PKT_W  = rbf_pkg::CNT_W'(rbf_pkg::PACKET_BYTES);

	// room left after other fields; cell bursts also lose the prefix
	wire [rbf_pkg::CNT_W-1:0] room_raw = (burst.slot_bytes > burst.overhead_bytes) ?
		burst.slot_bytes - burst.overhead_bytes : '0;
	wire [rbf_pkg::CNT_W-1:0] prefix_w = rbf_pkg::CNT_W'(burst.prefix_bytes);
	wire [rbf_pkg::CNT_W-1:0] cell_room = (room_raw > prefix_w) ? room_raw - prefix_w : '0;
	wire [rbf_pkg::CNT_W-1:0] n_cells = units_in(cell_room, CELL_W);
	wire [rbf_pkg::CNT_W-1:0] n_pkts  = units_in(room_raw, PKT_W);
	wire [rbf_pkg::CNT_W-1:0] cell_bytes = rbf_pkg::CNT_W'(n_cells * CELL_W);
	wire [rbf_pkg::CNT_W-1:0] pkt_bytes  = rbf_pkg::CNT_W'(n_pkts * PKT_W);
	wire [rbf_pkg::CNT_W-1:0] traffic_bytes = burst.packet_mode ? pkt_bytes :
		cell_bytes + prefix_w;
	wire [rbf_pkg::CNT_W-1:0] upkeep_bytes = rbf_pkg::CNT_W'(burst.access_field_length);

	// packet traffic refused unless capability says it is supported
	wire pkt_ok = !burst.packet_mode || logon.cap_a.packet_traffic;
	wire [2:0] mob = logon.cap_c[rbf_pkg::CAPC_MOB_HI:rbf_pkg::CAPC_MOB_LO];
	wire loc_update = (mob == rbf_pkg::MOB_LOC_UPDATE);
	wire upd_ok = !loc_update || burst.hub_allows_update;
	wire logon_allowed = !burst.logged_on && upd_ok && logon_ok;
	wire kind_ok = (burst.kind == rbf_pkg::RBF_TRAFFIC) ? pkt_ok :
		(burst.kind == rbf_pkg::RBF_LOGON) ? logon_allowed : 1'b1;
	// upkeep takes any slot kind, the contention input changes nothing
	wire take = start && (state == RBF_IDLE);
	wire accept = take && kind_ok;
	wire [rbf_pkg::CNT_W-1:0] load_bytes = (burst.kind == rbf_pkg::RBF_TRAFFIC) ?
		traffic_bytes : (burst.kind == rbf_pkg::RBF_UPKEEP) ? upkeep_bytes : '0;

	// payload byte consumption: pop a byte when none is held
	wire step = bit_enable;
	wire need_byte = (state == RBF_PAYLOAD) && !byte_loaded && (bytes_left != '0);
	assign f_ready = need_byte;
	wire byte_done = step && byte_loaded && (bit_idx == 3'h0);
	wire pay_done = (state == RBF_PAYLOAD) && (bytes_left == '0) && !byte_loaded;
	wire pre_bit = pre_shift[rbf_pkg::PRE_MAX_BITS-1];
	wire logon_bit = logon_shift[rbf_pkg::LOGON_BITS-1];
	wire pay_bit = cur_byte[bit_idx];
	wire after_pre = (burst.kind == rbf_pkg::RBF_LOGON) ? 1'b1 : (load_bytes != '0);

	//////////////////////////////////////////////////////////////////////////
	// burst sequencer
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state <= RBF_IDLE;
		end else begin
			unique case (state)
				RBF_IDLE: begin
					if (accept) begin
						state <= RBF_PREAMBLE;
					end
				end
				RBF_PREAMBLE: begin
					if (step && pre_left <= rbf_pkg::PRE_LEN_W'(1)) begin
						state <= (cfg.kind == rbf_pkg::RBF_LOGON) ? RBF_LOGON_BITS :
							(cfg.kind == rbf_pkg::RBF_ACQUISITION) ? RBF_GUARD : RBF_PAYLOAD;
					end else if (pre_left == '0) begin
						state <= (cfg.kind == rbf_pkg::RBF_LOGON) ? RBF_LOGON_BITS :
							(cfg.kind == rbf_pkg::RBF_ACQUISITION) ? RBF_GUARD : RBF_PAYLOAD;
					end
				end
				RBF_LOGON_BITS: begin
					if (step && logon_left == 7'h01) begin
						state <= RBF_GUARD;
					end
				end
				RBF_PAYLOAD: begin
					if (pay_done) begin
						state <= RBF_GUARD;
					end
				end
				RBF_GUARD: begin
					state <= RBF_IDLE;
				end
			endcase
		end
	end

	// capture of burst setup and shift registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cfg         <= '0;
			pre_shift   <= '0;
			pre_left    <= '0;
			logon_shift <= '0;
			logon_left  <= '0;
			bytes_left  <= '0;
		end else if (accept) begin
			cfg         <= burst;
			pre_shift   <= preamble_pattern;
			pre_left    <= burst.preamble_bits;
			logon_shift <= logon_word;
			logon_left  <= 7'(rbf_pkg::LOGON_BITS);
			bytes_left  <= load_bytes;
		end else begin
			if (state == RBF_PREAMBLE && step && pre_left != '0) begin
				pre_shift <= pre_shift << 1;
				pre_left  <= pre_left - rbf_pkg::PRE_LEN_W'(1);
			end
			if (state == RBF_LOGON_BITS && step) begin
				logon_shift <= logon_shift << 1;
				logon_left  <= logon_left - 7'h01;
			end
			if (f_valid && f_ready) begin
				bytes_left <= bytes_left - rbf_pkg::CNT_W'(1);
			end
		end
	end

	// byte holder: msb first within each byte
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cur_byte    <= '0;
			byte_loaded <= 1'b0;
			bit_idx     <= 3'h7;
		end else if (f_valid && f_ready) begin
			cur_byte    <= f_data;
			byte_loaded <= 1'b1;
			bit_idx     <= 3'h7;
		end else if (state == RBF_PAYLOAD && step && byte_loaded) begin
			byte_loaded <= !byte_done;
			bit_idx     <= bit_idx - 3'h1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// serial output, all from flip-flops
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			tx_bit        <= 1'b0;
			tx_valid      <= 1'b0;
			tx_first      <= 1'b0;
			tx_guard      <= 1'b0;
			busy          <= 1'b0;
			refused       <= 1'b0;
			unit_count    <= '0;
			first_pending <= 1'b0;
		end else begin
			busy     <= (state != RBF_IDLE) || accept;
			tx_guard <= (state == RBF_GUARD);
			if (take) begin
				refused       <= !kind_ok;
				unit_count    <= burst.packet_mode ? n_pkts : n_cells;
				first_pending <= kind_ok && after_pre;
			end
			tx_valid <= 1'b0;
			tx_first <= 1'b0;
			if (step && state == RBF_PREAMBLE && pre_left != '0) begin
				tx_bit   <= pre_bit;
				tx_valid <= 1'b1;
			end else if (step && state == RBF_LOGON_BITS) begin
				tx_bit        <= logon_bit;
				tx_valid      <= 1'b1;
				tx_first      <= first_pending;
				first_pending <= 1'b0;
			end else if (step && state == RBF_PAYLOAD && byte_loaded) begin
				tx_bit        <= pay_bit;
				tx_valid      <= 1'b1;
				tx_first      <= first_pending;
				first_pending <= 1'b0;
			end
		end
	end
endmodule

// File: tb/rbf_asserts.sv
// assertion checker bound to the formatter ports
`timescale 1ns/100ps
module rbf_asserts (
	input wire logic                   core_clk,
	input wire logic                   nrst,
	input wire logic                   start,
	input wire rbf_pkg::rbf_burst_type burst,
	input wire rbf_pkg::rbf_logon_type logon,
	input wire logic                   bit_enable,
	input wire logic                   tx_valid,
	input wire logic                   tx_first,
	input wire logic                   tx_guard,
	input wire logic                   busy,
	input wire logic                   refused
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// a request seen by an idle formatter, the logon kind
	wire take = start && !busy;
	wire is_logon = burst.kind == rbf_pkg::RBF_LOGON;
	////////////////////////////////////////////////////////////////////////
	property p_guard_one;
		tx_guard |=> !tx_guard;
	endproperty
	a_guard_one: assert property (p_guard_one) else $error("guard too long");
	property p_busy_end;
		tx_guard |-> ##[1:2] !busy;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy after guard");
	property p_first_valid;
		tx_first |-> tx_valid;
	endproperty
	a_first_valid: assert property (p_first_valid) else $error("lone first");
	property p_valid_en;
		tx_valid |-> $past(bit_enable);
	endproperty
	a_valid_en: assert property (p_valid_en) else $error("bit without enable");
	property p_ref_idle;
		$rose(refused) |-> !busy;
	endproperty
	a_ref_idle: assert property (p_ref_idle) else $error("refused but busy");
	// refusals: the two cycles after a single refused request must stay idle; an acquisition request must be taken
	property p_pkt_ref;
		take && !$past(take) && burst.packet_mode && !logon.cap_a.packet_traffic
			&& burst.kind == rbf_pkg::RBF_TRAFFIC |=> !busy [*2];
	endproperty
	a_pkt_ref: assert property (p_pkt_ref) else $error("packet burst taken");
	property p_lon_ref;
		take && !$past(take) && is_logon && burst.logged_on |=> !busy [*2];
	endproperty
	a_lon_ref: assert property (p_lon_ref) else $error("logon while on");
	property p_mob_ref;
		take && !$past(take) && is_logon && !burst.hub_allows_update
			&& logon.cap_c[6:4] == rbf_pkg::MOB_LOC_UPDATE |=> !busy [*2];
	endproperty
	a_mob_ref: assert property (p_mob_ref) else $error("update not allowed");
	property p_acq_take;
		take && !$past(take) && burst.kind == rbf_pkg::RBF_ACQUISITION |-> ##[1:2] busy;
	endproperty
	a_acq_take: assert property (p_acq_take) else $error("acquisition lost");
endmodule
bind rbf_formatter rbf_asserts u_chk (.core_clk, .nrst, .start, .burst, .logon, .bit_enable,
	.tx_valid, .tx_first, .tx_guard, .busy, .refused);

// File: tb/rbf_sink.sv
// far-side bit consumer standing in for the randomizer
`timescale 1ns/100ps
module rbf_sink (
	input  wire logic       core_clk,
	input  wire logic       clr,
	input  wire logic [1:0] mode,
	input  wire logic       tx_bit,
	input  wire logic       tx_valid,
	input  wire logic       tx_first,
	output logic            bit_enable,
	output logic [127:0]    word,
	output int              nbits,
	output int              first_at
);
	logic ph = 1'h0;
	initial bit_enable = 1'h0;
	// mode 0 stalls, 1 takes every other cycle, 2 every cycle
	always @(posedge core_clk) begin
		ph <= ~ph;
		bit_enable <= (mode == 2'h2) || (mode == 2'h1 && ph);
		if (clr) begin
			nbits <= 0;
			first_at <= -1;
		end else if (tx_valid) begin
			word <= {word[126:0], tx_bit};
			nbits <= nbits + 1;
			if (tx_first)
				first_at <= nbits;
		end
	end
endmodule

// File: tb/rbf_formatter_tb.sv
// self-checking bench for the return burst formatter
`timescale 1ns/100ps
`define CK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %0h got %0h", nm, e, a); end end
module rbf_formatter_tb;
	typedef struct packed {
		logic [23:0] ca;
		logic [1:0]  ver;
		logic [2:0]  mob;
		logic        lo;
		logic        hub;
		logic        rf;
	} rbf_row_type;
	logic                   core_clk = 1'h0;
	logic                   nrst = 1'h0;
	logic                   start = 1'h0;
	logic                   in_valid = 1'h0;
	logic [7:0]             in_byte = 8'h00;
	logic [1:0]             mode = 2'h2;
	rbf_pkg::rbf_burst_type burst = '0;
	rbf_pkg::rbf_logon_type logon = '0;
	logic [255:0]           pat = {8'hB4, 248'h0};
	logic                   in_ready, bit_enable, tx_bit, tx_valid, tx_first, tx_guard;
	logic                   busy, refused;
	logic [15:0]            unit_count;
	logic [127:0]           word;
	int                     nbits, first_at;
	int                     error_cnt = 0;
	int                     n_tests = 0;
	// logon cases: capability A, version, mobility, logged on, hub, refused
	rbf_row_type rows [8] = '{
		'{24'hA5C36E, 2'h2, 3'h7, 1'h0, 1'h0, 1'h0},
		'{24'h5A3C91, 2'h3, 3'h1, 1'h0, 1'h0, 1'h0},
		'{24'h0C0001, 2'h2, 3'h7, 1'h0, 1'h0, 1'h1},
		'{24'h000003, 2'h2, 3'h7, 1'h0, 1'h0, 1'h1},
		'{24'h000001, 2'h1, 3'h7, 1'h0, 1'h0, 1'h1},
		'{24'h000001, 2'h2, 3'h7, 1'h1, 1'h0, 1'h1},
		'{24'h000001, 2'h2, 3'h0, 1'h0, 1'h0, 1'h1},
		'{24'h000001, 2'h2, 3'h0, 1'h0, 1'h1, 1'h0}};
	rbf_formatter u_dut (.core_clk(core_clk), .nrst(nrst), .start(start), .burst(burst),
		.logon(logon), .preamble_pattern(pat), .in_byte(in_byte), .in_valid(in_valid),
		.in_ready(in_ready), .bit_enable(bit_enable), .tx_bit(tx_bit), .tx_valid(tx_valid),
		.tx_first(tx_first), .tx_guard(tx_guard), .busy(busy), .refused(refused),
		.unit_count(unit_count));
	rbf_sink u_sink (.core_clk(core_clk), .clr(start), .mode(mode), .tx_bit(tx_bit),
		.tx_valid(tx_valid), .tx_first(tx_first), .bit_enable(bit_enable), .word(word),
		.nbits(nbits), .first_at(first_at));
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one burst: request, push bytes i0..nb-1, wait for the end bounded
	task run(input int nb, input int i0);
		int i, t;
		logic rd, seen;
		i = i0;
		t = 0;
		seen = 1'h0;
		start = 1'h1;
		@(posedge core_clk);
		#2 start = 1'h0;
		while (!(seen ? !busy : t > 5) || i < nb) begin
			rd = in_ready;
			in_valid = i < nb;
			in_byte = i[7:0];
			@(posedge core_clk);
			#2 if (in_valid && rd) i++;
			seen |= busy;
			t++;
			if (t > 30000) begin
				error_cnt++;
				wrap_up;
			end
		end
		in_valid = 1'h0;
		$display("burst done after %0d cycles, mismatches %0d", t, error_cnt);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk);
		#2 nrst = 1'h1;
		`CK("in_ready", 1'h1, in_ready)
		`CK("busy", 1'h0, busy)
		logon.mac_address = 48'h0123456789AB;
		logon.downlink_route_field = 16'hBEEF;
		logon.cap_b = 5'h15;
		burst.kind = rbf_pkg::RBF_LOGON;
		burst.preamble_bits = 9'h008;
		for (int r = 0; r < 8; r++) begin
			logon.cap_a = rows[r].ca;
			logon.version = rows[r].ver;
			logon.cap_c = {1'h1, rows[r].mob, 4'h5};
			burst.logged_on = rows[r].lo;
			burst.hub_allows_update = rows[r].hub;
			mode = {~r[0], r[0]};
			run(0, 0);
			`CK("refused", rows[r].rf, refused)
			if (!rows[r].rf) begin
				`CK("nbits", 120, nbits)
				`CK("first", 8, first_at)
				`CK("word", {pat[255:248], rows[r].ca, 48'h0123456789AB, 16'hBEEF, 5'h15,
					rows[r].ver, 1'h1, rows[r].mob, 4'h5, 8'h00, 1'h1}, word[119:0])
			end
		end
		// bytes may queue while idle; fill with the far side stalled
		mode = 2'h0;
		in_valid = 1'h1;
		for (int k = 0; k < 8; k++) begin
			in_byte = k[7:0];
			@(posedge core_clk);
			#2;
		end
		in_valid = 1'h0;
		`CK("in_ready", 1'h0, in_ready)
		burst.kind = rbf_pkg::RBF_TRAFFIC;
		burst.prefix_bytes = 8'h01;
		burst.overhead_bytes = 16'h0004;
		burst.slot_bytes = 16'h006F;
		mode = 2'h1;
		run(107, 8);
		`CK("cells", 16'h0002, unit_count)
		`CK("nbits", 864, nbits)
		`CK("last", 8'h6A, word[7:0])
		burst.packet_mode = 1'h1;
		run(0, 0);
		`CK("refused", 1'h1, refused)
		logon.cap_a.packet_traffic = 1'h1;
		burst.slot_bytes = 16'h017C;
		mode = 2'h2;
		run(376, 0);
		`CK("packets", 16'h0002, unit_count)
		`CK("nbits", 3016, nbits)
		`CK("last", 8'h77, word[7:0])
		burst.kind = rbf_pkg::RBF_UPKEEP;
		burst.access_field_length = 8'h02;
		burst.contention = 1'h1;
		run(2, 0);
		`CK("refused", 1'h0, refused)
		`CK("nbits", 24, nbits)
		`CK("access", 16'h0001, word[15:0])
		burst.kind = rbf_pkg::RBF_ACQUISITION;
		burst.preamble_bits = 9'h010;
		run(0, 0);
		`CK("nbits", 16, nbits)
		`CK("first", -1, first_at)
		`CK("preamble", 16'hB400, word[15:0])
		// reset in mid-burst must drop everything at once
		mode = 2'h1;
		start = 1'h1;
		@(posedge core_clk);
		#2 start = 1'h0;
		repeat (6) @(posedge core_clk);
		#2 nrst = 1'h0;
		@(posedge core_clk);
		#2 nrst = 1'h1;
		`CK("busy", 1'h0, busy)
		`CK("tx_valid", 1'h0, tx_valid)
		$display("reset test done, mismatches %0d", error_cnt);
		wrap_up;
	end
endmodule
